/* src/sbd_pkg.sv */
// package for the system bus decoder and abort controller
//
// What this block does
// [RL1] only little-endian transfers exist; no big-endian byte lane mapping
// [RL2] fixed priority: dma engine wins over processor when both request
// [RL3] top address nibble: 0x0 internal memories, 0xf peripherals, others undefined
// [RL4] access to any of the fourteen undefined regions aborts
// [RL5] internal region decodes eight more bits into 1-Mbyte memory slots
// [RL6] each memory aliases throughout its slot, ignoring upper address bits
// [RL7] access to an empty internal slot aborts
// [RL8] area 0 maps to flash before remap, to sram after remap
// [RL9] memory in area 0 also stays reachable at its own slot
// [RL10] writing one to remap toggle bit toggles remap; zero does nothing
// [RL11] abort indication goes to every master
// [RL12] dma ignores abort; processor acts only on its own access
// [RL13] full 32-bit aborted address is captured
// [RL14] size and access type of aborted transfer are recorded
// [RL15] cause flag tells undefined from misaligned address
// [RL16] last source flag per master names the latest aborting master
// [RL17] sticky per-master abort flag unless shown by last source flag
// [RL18] misaligned word or half-word accesses abort and are cancelled
// [RL19] processor instruction fetches skip the alignment check
// [RL20] size code: 00 byte, 01 half-word, 10 word
// [RL21] type code: 00 data read, 01 data write, 10 fetch
// [RL22] reading abort status clears both sticky flags
// [RL23] reset clears remap and all abort status and address fields
// [RL24] each new abort overwrites address, size, type, cause and source
package sbd_pkg;
    // ==================================================
    // register map (byte addresses)
    localparam logic [7:0] REG_REMAP_COMMAND = 8'h00;
    localparam logic [7:0] REG_ABORT_STATUS = 8'h04;
    localparam logic [7:0] REG_ABORT_ADDRESS = 8'h08;

    // ==================================================
    // abort status and remap command field positions
    localparam int UNDEF_BIT = 0;
    localparam int MISAL_BIT = 1;
    localparam int SIZE_LSB = 8;
    localparam int TYPE_LSB = 10;
    localparam int SRC_DMA_BIT = 16;
    localparam int SRC_CPU_BIT = 17;
    localparam int STK_DMA_BIT = 24;
    localparam int STK_CPU_BIT = 25;
    localparam int REMAP_BIT = 0;

    // ==================================================
    // address decode
    localparam logic [3:0] REGION_INTERNAL = 4'h0;
    localparam logic [3:0] REGION_PERIPH = 4'hf;
    localparam logic [7:0] SLOT_FLASH = 8'h01;
    localparam logic [7:0] SLOT_SRAM = 8'h02;
    localparam logic [7:0] SLOT_AREA0 = 8'h00;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

    // ==================================================
    // encodings
    typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} sbd_size_t;
    typedef enum logic [1:0] {TY_READ = 2'h0, TY_WRITE = 2'h1, TY_FETCH = 2'h2} sbd_type_t;
    typedef enum logic [1:0] {TGT_NONE = 2'h0, TGT_FLASH = 2'h1, TGT_SRAM = 2'h2, TGT_PERIPH = 2'h3} sbd_tgt_t;

    // master request carrier
    typedef struct packed {
        logic req;
        logic [31:0] addr;
        sbd_size_t size;
        sbd_type_t kind;
    } sbd_req_t;

    // apb request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sbd_apb_t;
endpackage

/* src/sbd_bus_ctrl.sv */
// system bus arbiter, decoder, misalignment detector and abort status
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module sbd_bus_ctrl #(
    parameter int FLASH_AW = 17,
    parameter int SRAM_AW = 15
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire sbd_pkg::sbd_req_t dmaReq,
    input wire sbd_pkg::sbd_req_t cpuReq,
    input wire sbd_pkg::sbd_apb_t apbIn,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic dmaGrant,
    output logic cpuGrant,
    output logic abortOut,
    output sbd_pkg::sbd_tgt_t selTarget,
    output logic [31:0] memAddr,
    output logic remapped
);
    import sbd_pkg::*;

    // all state of the block
    typedef struct packed {
        logic remap;
        logic [31:0] abtAddr;
        sbd_size_t abtSize;
        sbd_type_t abtType;
        logic undef;
        logic misal;
        logic srcDma;
        logic srcCpu;
        logic stkDma;
        logic stkCpu;
        logic dmaGnt;
        logic cpuGnt;
        logic abort;
        sbd_tgt_t tgt;
        logic [31:0] mAddr;
        logic [31:0] rdata;
        logic ready;
    } sbd_state_t;

    sbd_state_t st_q;
    sbd_state_t st_d;
    sbd_req_t win;
    sbd_tgt_t tgtDec;
    logic [31:0] offDec;
    logic undefHit;
    logic misHit;
    logic abtHit;
    logic apbAcc;
    logic [31:0] statusWord;

    // ==================================================
    // decode helpers

    // aliased offset inside a memory of 2**aw bytes
    function automatic logic [31:0] alias_off(input logic [31:0] a, input int aw);
        logic [31:0] mask;
        mask = (32'h0000_0001 << aw) - 32'h0000_0001;
        return a & mask;
    endfunction

    // alignment check; fetches are never checked
    function automatic logic misaligned(input sbd_req_t r);
        logic bad;
        bad = 1'b0;
        if (r.kind != TY_FETCH) begin // RL19
            if (r.size == SZ_WORD) begin
                bad = (r.addr[1:0] != 2'h0); // RL18
            end else if (r.size == SZ_HALF) begin
                bad = r.addr[0]; // RL18
            end
        end
        return bad;
    endfunction

    // ==================================================
    // arbitration and address decode
    always_comb begin
        // dma is hard-wired above the processor; byte lanes are little-endian only, no swap path
        // RL1
        win = dmaReq.req ? dmaReq : cpuReq; // RL2
        tgtDec = TGT_NONE;
        offDec = RESET_ZERO;
        if (win.addr[31:28] == REGION_PERIPH) begin // RL3
            tgtDec = TGT_PERIPH;
            offDec = win.addr;
        end else if (win.addr[31:28] == REGION_INTERNAL) begin // RL5
            case (win.addr[27:20])
                SLOT_AREA0: begin
                    // area 0 follows the remap state, both slots stay live
                    if (st_q.remap) begin // RL8 RL9
                        tgtDec = TGT_SRAM;
                        offDec = alias_off(win.addr, SRAM_AW); // RL6
                    end else begin
                        tgtDec = TGT_FLASH;
                        offDec = alias_off(win.addr, FLASH_AW); // RL6
                    end
                end
                SLOT_FLASH: begin
                    tgtDec = TGT_FLASH;
                    offDec = alias_off(win.addr, FLASH_AW); // RL6
                end
                SLOT_SRAM: begin
                    tgtDec = TGT_SRAM;
                    offDec = alias_off(win.addr, SRAM_AW); // RL6
                end
                default: begin
                    tgtDec = TGT_NONE; // RL7
                end
            endcase
        end
        // undefined regions and empty slots both land here
        undefHit = win.req && (tgtDec == TGT_NONE); // RL4 RL7
        misHit = win.req && misaligned(win);
        abtHit = undefHit || misHit;
    end

    // status word as software sees it
    always_comb begin
        statusWord = RESET_ZERO;
        statusWord[UNDEF_BIT] = st_q.undef;
        statusWord[MISAL_BIT] = st_q.misal;
        statusWord[SIZE_LSB +: 2] = st_q.abtSize;
        statusWord[TYPE_LSB +: 2] = st_q.abtType;
        statusWord[SRC_DMA_BIT] = st_q.srcDma;
        statusWord[SRC_CPU_BIT] = st_q.srcCpu;
        statusWord[STK_DMA_BIT] = st_q.stkDma;
        statusWord[STK_CPU_BIT] = st_q.stkCpu;
    end

    // ==================================================
    // next state
    always_comb begin
        st_d = st_q;
        // apb answers in the access phase with zero wait states
        apbAcc = apbIn.psel && apbIn.penable;
        st_d.ready = apbIn.psel && !apbIn.penable;
        st_d.dmaGnt = dmaReq.req;
        st_d.cpuGnt = !dmaReq.req && cpuReq.req;
        // abort goes to all masters; the cpu alone decides to take it
        st_d.abort = abtHit; // RL11 RL12
        // a cancelled access selects nothing downstream
        st_d.tgt = abtHit ? TGT_NONE : (win.req ? tgtDec : TGT_NONE); // RL18
        st_d.mAddr = offDec;
        st_d.rdata = RESET_ZERO;
        if (apbIn.psel && !apbIn.penable && !apbIn.pwrite) begin
            case (apbIn.paddr)
                REG_ABORT_STATUS: st_d.rdata = statusWord;
                REG_ABORT_ADDRESS: st_d.rdata = st_q.abtAddr;
                default: st_d.rdata = RESET_ZERO;
            endcase
        end
        if (apbAcc && st_q.ready && apbIn.pwrite && apbIn.paddr == REG_REMAP_COMMAND) begin
            if (apbIn.pwdata[REMAP_BIT]) begin
                st_d.remap = !st_q.remap; // RL10
            end
        end
        // read clears sticky flags; a same-cycle abort below sets again only the flag of the source it displaces
        if (apbAcc && st_q.ready && !apbIn.pwrite && apbIn.paddr == REG_ABORT_STATUS) begin
            st_d.stkDma = 1'b0; // RL22
            st_d.stkCpu = 1'b0; // RL22
        end
        if (abtHit) begin
            // keep a displaced source visible as sticky before overwriting
            if (st_q.srcDma && !dmaReq.req) begin
                st_d.stkDma = 1'b1; // RL17
            end
            if (st_q.srcCpu && dmaReq.req) begin
                st_d.stkCpu = 1'b1; // RL17
            end
            st_d.abtAddr = win.addr; // RL13 RL24
            st_d.abtSize = win.size; // RL14 RL20
            st_d.abtType = win.kind; // RL14 RL21
            st_d.undef = undefHit; // RL15
            st_d.misal = !undefHit; // RL15
            st_d.srcDma = dmaReq.req; // RL16
            st_d.srcCpu = !dmaReq.req; // RL16
        end
    end

    // ==================================================
    // state register; everything clears to zero and unmapped
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0; // RL23
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops, except pslverr which is tied low
    assign prdata = st_q.rdata;
    assign pready = st_q.ready;
    assign pslverr = 1'b0;
    assign dmaGrant = st_q.dmaGnt;
    assign cpuGrant = st_q.cpuGnt;
    assign abortOut = st_q.abort;
    assign selTarget = st_q.tgt;
    assign memAddr = st_q.mAddr;
    assign remapped = st_q.remap;

    // ==================================================
    // checks
    sequence s_undefReq;
        win.req && (win.addr[31:28] != REGION_INTERNAL) && (win.addr[31:28] != REGION_PERIPH);
    endsequence

    chk_undef_abort: assert property (@(posedge clock) disable iff (!rst_b) // RL4
        s_undefReq |=> abortOut && st_q.undef && !st_q.misal)
        else $error("undefined region did not abort");
    chk_dma_priority: assert property (@(posedge clock) disable iff (!rst_b) // RL2
        dmaReq.req && cpuReq.req |=> dmaGrant && !cpuGrant)
        else $error("processor granted over dma");
    chk_fetch_noalign: assert property (@(posedge clock) disable iff (!rst_b) // RL19
        win.req && win.kind == TY_FETCH && tgtDec != TGT_NONE |=> !abortOut)
        else $error("fetch raised an abort");
    chk_word_misalign: assert property (@(posedge clock) disable iff (!rst_b) // RL18
        win.req && win.kind != TY_FETCH && win.size == SZ_WORD && win.addr[1:0] != 2'h0
        |=> abortOut && selTarget == TGT_NONE)
        else $error("misaligned word not cancelled");
    chk_abort_addr: assert property (@(posedge clock) disable iff (!rst_b) // RL13
        abtHit |=> st_q.abtAddr == $past(win.addr))
        else $error("abort address not captured");
    chk_remap_toggle: assert property (@(posedge clock) disable iff (!rst_b) // RL10
        apbAcc && pready && apbIn.pwrite && apbIn.paddr == REG_REMAP_COMMAND
        |=> remapped == ($past(remapped) ^ $past(apbIn.pwdata[REMAP_BIT])))
        else $error("remap did not toggle");
    chk_area0_map: assert property (@(posedge clock) disable iff (!rst_b) // RL8
        win.req && !abtHit && win.addr[31:20] == 12'h000
        |=> selTarget == ($past(remapped) ? TGT_SRAM : TGT_FLASH))
        else $error("area zero mapped wrongly");
    chk_sticky_clear: assert property (@(posedge clock) disable iff (!rst_b) // RL22
        apbAcc && pready && !apbIn.pwrite && apbIn.paddr == REG_ABORT_STATUS && !abtHit
        |=> !st_q.stkDma && !st_q.stkCpu)
        else $error("sticky flags survived a status read");
    chk_source_flag: assert property (@(posedge clock) disable iff (!rst_b) // RL16
        abtHit |=> st_q.srcDma != st_q.srcCpu)
        else $error("source flags not one-hot");

    // requests landing in the two populated memory slots
    sequence s_flashSlotReq;
        win.req && !misHit && (win.addr[31:20] == 12'h001);
    endsequence
    sequence s_sramSlotReq;
        win.req && !misHit && (win.addr[31:20] == 12'h002);
    endsequence

    // peripheral region passes the whole address through
    chk_periph_select: assert property (@(posedge clock) disable iff (!rst_b) // RL3
        win.req && !misHit && win.addr[31:28] == REGION_PERIPH |=> selTarget == TGT_PERIPH && memAddr == $past(win.addr))
        else $error("peripheral access not selected");

    // slots above the sram slot hold no memory
    chk_empty_slot: assert property (@(posedge clock) disable iff (!rst_b) // RL7
        win.req && win.addr[31:28] == REGION_INTERNAL && win.addr[27:20] > SLOT_SRAM
        |=> abortOut && selTarget == TGT_NONE && st_q.undef)
        else $error("empty slot did not abort");

    // flash repeats through its slot
    chk_flash_alias: assert property (@(posedge clock) disable iff (!rst_b) // RL6
        s_flashSlotReq |=> selTarget == TGT_FLASH
        && memAddr == ($past(win.addr) & ((32'h0000_0001 << FLASH_AW) - 32'h0000_0001)))
        else $error("flash alias offset wrong");

    // sram repeats through its own slot, also after a remap
    chk_sram_alias: assert property (@(posedge clock) disable iff (!rst_b) // RL6 RL9
        s_sramSlotReq |=> selTarget == TGT_SRAM
        && memAddr == ($past(win.addr) & ((32'h0000_0001 << SRAM_AW) - 32'h0000_0001)))
        else $error("sram alias offset wrong");

    // abort is broadcast the cycle after the offending request
    chk_abort_bcast: assert property (@(posedge clock) disable iff (!rst_b) // RL11
        abtHit |=> abortOut)
        else $error("abort not broadcast");

    // no abort without an offending request
    chk_abort_quiet: assert property (@(posedge clock) disable iff (!rst_b) // RL11
        !abtHit |=> !abortOut)
        else $error("spurious abort");

    // size and type of the aborted transfer are kept
    chk_abort_record: assert property (@(posedge clock) disable iff (!rst_b) // RL14 RL24
        abtHit |=> st_q.abtSize == $past(win.size) && st_q.abtType == $past(win.kind))
        else $error("abort size or type not captured");

    // exactly one cause flag per abort
    chk_cause_flag: assert property (@(posedge clock) disable iff (!rst_b) // RL15
        abtHit |=> st_q.undef != st_q.misal)
        else $error("cause flags not exclusive");

    // odd half-word addresses are cancelled
    chk_half_misalign: assert property (@(posedge clock) disable iff (!rst_b) // RL18
        win.req && win.kind != TY_FETCH && win.size == SZ_HALF && win.addr[0] |=> abortOut && selTarget == TGT_NONE)
        else $error("misaligned half-word not cancelled");

    // reserved size code never recorded
    chk_size_code: assert property (@(posedge clock) disable iff (!rst_b) // RL20
        st_q.abtSize != 2'h3)
        else $error("reserved size code recorded");

    // reserved type code never recorded
    chk_type_code: assert property (@(posedge clock) disable iff (!rst_b) // RL21
        st_q.abtType != 2'h3)
        else $error("reserved type code recorded");

    // a cpu abort displacing a dma source keeps the dma one sticky
    chk_sticky_dma: assert property (@(posedge clock) disable iff (!rst_b) // RL17
        abtHit && st_q.srcDma && !dmaReq.req |=> st_q.stkDma)
        else $error("dma sticky flag lost");

    // a dma abort displacing a cpu source keeps the cpu one sticky
    chk_sticky_cpu: assert property (@(posedge clock) disable iff (!rst_b) // RL17
        abtHit && st_q.srcCpu && dmaReq.req |=> st_q.stkCpu)
        else $error("cpu sticky flag lost");

    // captured address only moves on a new abort
    chk_addr_hold: assert property (@(posedge clock) disable iff (!rst_b) // RL24
        !abtHit |=> $stable(st_q.abtAddr))
        else $error("abort address changed without abort");

    // remap state only moves on a toggle write
    chk_remap_hold: assert property (@(posedge clock) disable iff (!rst_b) // RL10
        !(apbAcc && pready && apbIn.pwrite && apbIn.paddr == REG_REMAP_COMMAND && apbIn.pwdata[REMAP_BIT])
        |=> $stable(remapped))
        else $error("remap changed without toggle");

    // status read returns the packed status fields
    chk_status_read: assert property (@(posedge clock) disable iff (!rst_b) // RL14
        apbIn.psel && !apbIn.penable && !apbIn.pwrite && apbIn.paddr == REG_ABORT_STATUS
        |=> prdata == $past(statusWord))
        else $error("status read data wrong");

    // ready is a single-cycle pulse
    chk_ready_pulse: assert property (@(posedge clock) disable iff (!rst_b)
        pready |=> !pready)
        else $error("ready held too long");

    // processor alone gets the bus when dma is idle
    chk_cpu_grant: assert property (@(posedge clock) disable iff (!rst_b) // RL2
        cpuReq.req && !dmaReq.req |=> cpuGrant && !dmaGrant)
        else $error("processor not granted");

    // held reset keeps remap and status cleared
    chk_reset_state: assert property (@(posedge clock) // RL23
        !rst_b |-> !remapped && st_q.abtAddr == RESET_ZERO && statusWord == RESET_ZERO)
        else $error("state not cleared in reset");
endmodule

/* testbench/sbd_master_model.sv */
// behavioural model of the dma engine and processor bus masters
`timescale 1ns/10ps
module sbd_master_model (
    input wire logic clock,
    input wire logic abortOut,
    output sbd_pkg::sbd_req_t dmaReq,
    output sbd_pkg::sbd_req_t cpuReq
);
    import sbd_pkg::*;
    logic cpuPending;
    logic cpuTookAbort;
    initial begin
        dmaReq = '0;
        cpuReq = '0;
    end
    // ==================================================
    // one request cycle per call, little-endian only, then the bus is released
    task automatic issue(input logic toDma, input logic toCpu, input logic [31:0] a, input sbd_size_t sz,
                         input sbd_type_t ty);
        sbd_req_t r;
        r = '{req: 1'b1, addr: a, size: sz, kind: ty};
        @(posedge clock);
        if (toDma) dmaReq <= r;
        if (toCpu) cpuReq <= r;
        @(posedge clock);
        // released address shows the inverse so a stale value cannot pass
        r = '{req: 1'b0, addr: ~a, size: sz, kind: ty};
        dmaReq <= r;
        cpuReq <= r;
    endtask
    // ==================================================
    // dma ignores abort; processor only heeds it after its own request
    always @(posedge clock) begin
        cpuPending <= cpuReq.req;
        cpuTookAbort <= abortOut && cpuPending;
    end
endmodule

/* testbench/system_bus_decode_abort_ctrl_tb.sv */
// self-checking testbench of the bus decoder and abort controller
`timescale 1ns/10ps
module system_bus_decode_abort_ctrl_tb;
    import sbd_pkg::*;
    logic clock;
    logic rst_b;
    sbd_apb_t apb;
    sbd_req_t dmaReq;
    sbd_req_t cpuReq;
    logic [31:0] prdata;
    logic [31:0] memAddr;
    logic pready;
    logic dmaGrant;
    logic cpuGrant;
    logic abortOut;
    logic remapped;
    sbd_tgt_t selTarget;
    int num_errors;
    int n_tests;
    int cycles = 0;
    sbd_bus_ctrl #(.FLASH_AW(17), .SRAM_AW(15)) DUT (.clock(clock), .rst_b(rst_b), .dmaReq(dmaReq),
        .cpuReq(cpuReq), .apbIn(apb), .prdata(prdata), .pready(pready), .pslverr(), .dmaGrant(dmaGrant),
        .cpuGrant(cpuGrant), .abortOut(abortOut), .selTarget(selTarget), .memAddr(memAddr), .remapped(remapped));
    sbd_master_model MST (.clock(clock), .abortOut(abortOut), .dmaReq(dmaReq), .cpuReq(cpuReq));
    // ==================================================
    // shared helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] st(input logic u, m, input logic [1:0] sz, ty, input logic sd, sc, kd, kc);
        return (32'(u) << UNDEF_BIT) | (32'(m) << MISAL_BIT) | (32'(sz) << SIZE_LSB) | (32'(ty) << TYPE_LSB)
            | (32'(sd) << SRC_DMA_BIT) | (32'(sc) << SRC_CPU_BIT) | (32'(kd) << STK_DMA_BIT) | (32'(kc) << STK_CPU_BIT);
    endfunction
    // apb transfer: hold everything until pready is sampled high
    task automatic apb_rw(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clock);
        apb.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        apb_rw(1'b0, a, 32'h0, v);
        chk(what, exp, v);
    endtask
    task automatic wr_remap(input logic [31:0] wd, input logic expRemap);
        logic [31:0] v;
        apb_rw(1'b1, REG_REMAP_COMMAND, wd, v);
        #1;
        chk("remapped", 32'(expRemap), 32'(remapped));
    endtask
    // one master request and the registered answer a cycle later
    task automatic acc(input logic d, c, input logic [31:0] a, input sbd_size_t s, input sbd_type_t t, input logic ab,
                       input sbd_tgt_t tg, input logic [31:0] ma);
        MST.issue(d, c, a, s, t);
        #1;
        chk("abort", 32'(ab), 32'(abortOut));
        chk("target", 32'(tg), 32'(selTarget));
        chk("grants", {30'h0, d, c & ~d}, {30'h0, dmaGrant, cpuGrant});
        if (!ab) chk("memaddr", ma, memAddr);
    endtask
    // ==================================================
    // scenarios
    task automatic t_reset();
        chk("remap after reset", 32'h0, 32'(remapped));
        rd_chk(REG_ABORT_STATUS, 32'h0, "status reset");
        rd_chk(REG_ABORT_ADDRESS, 32'h0, "address reset");
        rd_chk(8'h0c, 32'h0, "unmapped read");
    endtask
    task automatic t_decode();
        acc(0, 1, 32'h0013_2344, SZ_WORD, TY_READ, 0, TGT_FLASH, 32'h0001_2344);
        acc(0, 1, 32'h0020_8004, SZ_WORD, TY_WRITE, 0, TGT_SRAM, 32'h0000_0004);
        acc(1, 0, 32'hf000_1234, SZ_WORD, TY_READ, 0, TGT_PERIPH, 32'hf000_1234);
        acc(0, 1, 32'h0000_0010, SZ_WORD, TY_READ, 0, TGT_FLASH, 32'h0000_0010);
        acc(0, 1, 32'h0030_0000, SZ_BYTE, TY_READ, 1, TGT_NONE, 32'h0);
        acc(1, 1, 32'h0010_0000, SZ_WORD, TY_READ, 0, TGT_FLASH, 32'h0);
    endtask
    task automatic t_undef();
        for (int r = 1; r < 15; r++) acc(0, 1, {r[3:0], 28'h0}, SZ_BYTE, TY_READ, 1, TGT_NONE, 32'h0);
        acc(0, 1, 32'h3000_0000, SZ_WORD, TY_READ, 1, TGT_NONE, 32'h0);
        rd_chk(REG_ABORT_STATUS, st(1, 0, SZ_WORD, TY_READ, 0, 1, 0, 0), "status undef");
        rd_chk(REG_ABORT_ADDRESS, 32'h3000_0000, "address undef");
    endtask
    task automatic t_misalign();
        acc(1, 0, 32'h0010_0001, SZ_HALF, TY_WRITE, 1, TGT_NONE, 32'h0);
        rd_chk(REG_ABORT_STATUS, st(0, 1, SZ_HALF, TY_WRITE, 1, 0, 0, 1), "status misal");
        rd_chk(REG_ABORT_ADDRESS, 32'h0010_0001, "address misal");
        rd_chk(REG_ABORT_STATUS, st(0, 1, SZ_HALF, TY_WRITE, 1, 0, 0, 0), "status reread");
        acc(0, 1, 32'h0010_0002, SZ_WORD, TY_FETCH, 0, TGT_FLASH, 32'h0000_0002);
        acc(0, 1, 32'h0010_0003, SZ_BYTE, TY_READ, 0, TGT_FLASH, 32'h0000_0003);
        acc(0, 1, 32'h0010_0002, SZ_WORD, TY_READ, 1, TGT_NONE, 32'h0);
        rd_chk(REG_ABORT_STATUS, st(0, 1, SZ_WORD, TY_READ, 0, 1, 1, 0), "status fetch");
    endtask
    task automatic t_remap();
        wr_remap(32'h0000_0000, 1'b0);
        wr_remap(32'h0000_0001, 1'b1);
        acc(0, 1, 32'h0000_8004, SZ_WORD, TY_READ, 0, TGT_SRAM, 32'h0000_0004);
        acc(0, 1, 32'h0010_0008, SZ_WORD, TY_READ, 0, TGT_FLASH, 32'h0000_0008);
        wr_remap(32'h0000_0001, 1'b0);
        acc(0, 1, 32'h0000_0004, SZ_WORD, TY_READ, 0, TGT_FLASH, 32'h0000_0004);
    endtask
    // ==================================================
    // closing report, reached from the main sequence or the timeout
    task print_verdict;
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // hang guard: whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        rst_b = 1'b0;
        apb = '0;
        num_errors = 0;
        n_tests = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_decode();
        t_undef();
        t_misalign();
        t_remap();
        print_verdict;
    end
endmodule
